// ==== sar_adc_serial_readout_bench.sv ====
// Purpose: host and converter joined, plus a bench-clocked converter
// Assumes: default host half period
// Notes:   second converter covers the LSB-first tail and aborts
`default_nettype none
module sar_adc_serial_readout_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        start = 1'b0;
  logic        cpol  = 1'b0;
  logic [15:0] vin   = 16'h0000;
  logic [15:0] vref  = 16'h1000;
  logic        ready, valid, busy, busy_b;
  logic [11:0] hcode, dcode, dcode_b;
  int          fails = 0;
  int          n_checks = 0;
  logic [15:0] tv [6] = '{16'd2243, 16'd1365, 16'd0, 16'd4095, 16'd5000, 16'd1000};
  logic [15:0] tr [6] = '{16'd4096, 16'd4096, 16'd4096, 16'd4096, 16'd4096, 16'd2000};
  logic [11:0] tc [6] = '{12'h8C3, 12'h555, 12'h000, 12'hFFF, 12'hFFF, 12'h800};
  sarsr_if link ();
  sarsr_if link_b ();
  sarsr_device i_sarsr_device (.i_clk(i_clk), .i_rst(i_rst), .link(link.device), .i_vin_mv(vin),
    .i_vref_mv(vref), .o_busy(busy), .o_code(dcode));
  sarsr_device i_sarsr_device_b (.i_clk(i_clk), .i_rst(i_rst), .link(link_b.device), .i_vin_mv(vin),
    .i_vref_mv(vref), .o_busy(busy_b), .o_code(dcode_b));
  sarsr_host i_sarsr_host (.i_clk(i_clk), .i_rst(i_rst), .link(link.host), .i_start(start), .i_cpol(cpol),
    .o_ready(ready), .o_valid(valid), .o_code(hcode));
  sarsr_assertions i_sarsr_assertions (.i_clk(i_clk), .i_rst(i_rst), .select_shutdown_n(link.select_shutdown_n),
    .sclk(link.sclk), .miso_o(link.miso_o), .miso_oe(link.miso_oe));
  // Clock
  always #5 i_clk = ~i_clk;
  // ******
  // Tasks
  // ******
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // One host-run conversion; a stuck handshake ends the run
  task automatic host_conv(input logic [15:0] v, input logic [15:0] r, input logic [11:0] exp);
    int k;
    vin = v;
    vref = r;
    for (k = 0; k < 100 && ready !== 1'b1; k++) tick(1);
    if (ready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (k = 0; k < 1000 && valid !== 1'b1; k++) tick(1);
    if (valid !== 1'b1) begin
      fails++;
      end_of_test();
    end
    chk(hcode, exp);
    chk(dcode, exp);
    chk({11'h000, busy}, 12'h001);
    tick(4);
    chk({11'h000, busy}, 12'h000);
  endtask : host_conv
  // Bench as host on the second link, irregular halves, sampled late in the low half
  task automatic dev_conv(input int n, input logic [11:0] exp);
    int   k;
    logic e;
    link_b.select_shutdown_n = 1'b0;
    tick(4);
    for (k = 1; k <= n; k++) begin
      link_b.sclk = 1'b1;
      tick(8 + 4 * (k % 3));
      link_b.sclk = 1'b0;
      tick(8 + 3 * (k % 2));
      e = (k <= 2) ? 1'b0 : (k <= 14) ? exp[14 - k] : (k <= 25) ? exp[k - 14] : 1'b0;
      if (k == 1) chk({11'h000, link_b.miso_oe}, 12'h000);
      else chk({10'h000, link_b.miso_oe, link_b.miso_o}, {10'h001, e});
      if (k == 5) chk({11'h000, busy_b}, 12'h001);
    end
    link_b.select_shutdown_n = 1'b1;
    tick(6);
    chk({10'h000, link_b.miso_oe, busy_b}, 12'h000);
  endtask : dev_conv
  // Main sequence
  initial begin
    link_b.select_shutdown_n = 1'b0;
    link_b.sclk = 1'b0;
    tick(16);
    i_rst = 1'b0;
    tick(5);
    // Select low from power-up: clocks must not start a transfer
    for (int p = 0; p < 4; p++) begin
      link_b.sclk = 1'b1;
      tick(9);
      link_b.sclk = 1'b0;
      tick(9);
    end
    chk({10'h000, link_b.miso_oe, busy_b}, 12'h000);
    link_b.select_shutdown_n = 1'b1;
    $display("power-up select test done");
    for (int m = 0; m < 12; m++) begin
      cpol = m[0];
      host_conv(tv[m / 2], tr[m / 2], tc[m / 2]);
    end
    $display("host conversions done");
    vin = 16'd2243;
    vref = 16'd4096;
    dev_conv(8, 12'h8C3);
    dev_conv(30, 12'h8C3);
    $display("bench-clocked conversions done");
    end_of_test();
  end
endmodule : sar_adc_serial_readout_bench
`default_nettype wire

// ==== sarsr_assertions.sv ====
// Purpose: wire checks beside the host/converter link
// Assumes: host half period of 9 clock cycles
// Notes:   falls counted on the raw wire once a rise is seen
`default_nettype none
module sarsr_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic select_shutdown_n,
  input wire logic sclk,
  input wire logic miso_o,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [5:0] falls_q;
  logic [5:0] falls_d;
  logic       seen_q;
  logic       seen_d;
  // Count falls ahead of the device's sync; a fall before the first rise (idle high) is no clock
  always_comb begin
    falls_d = falls_q;
    seen_d  = seen_q;
    if (select_shutdown_n) begin
      falls_d = 6'h00;
      seen_d  = 1'b0;
    end else begin
      if (!sclk_q && sclk) begin
        seen_d = 1'b1;
      end
      if (seen_q && sclk_q && !sclk) begin
        falls_d = falls_q + 6'h01;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    sclk_q  <= sclk;
    falls_q <= i_rst ? 6'h00 : falls_d;
    seen_q  <= i_rst ? 1'b0 : seen_d;
  end
  // ****************
  // Link properties
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_off_idle: assert property (select_shutdown_n [*5] |-> !miso_oe) else $error("driving deselected");
  a_first_hiz: assert property (!select_shutdown_n && falls_q < 6'h02 |-> !miso_oe) else $error("early drive");
  a_null_bit: assert property ($rose(miso_oe) |-> falls_q == 6'h02 && !miso_o) else $error("bad null");
  a_oe_holds: assert property (miso_oe && !select_shutdown_n |=> miso_oe) else $error("drive dropped");
  a_off_after: assert property ($rose(select_shutdown_n) |-> ##[1:5] !miso_oe) else $error("no standby");
  a_change_fall: assert property ($changed(miso_o) && miso_oe && !select_shutdown_n |-> !sclk && !$past(sclk, 2))
    else $error("change off falling edge");
  a_one_bit: assert property ($changed(miso_o) && miso_oe |=> ($stable(miso_o) || select_shutdown_n) [*7])
    else $error("two changes per clock");
  a_lsb_repeat: assert property ($fell(sclk) && !select_shutdown_n && falls_q == 6'h0E |->
    ##6 miso_o == $past(miso_o, 36)) else $error("bit one not repeated");
endmodule : sarsr_assertions
`default_nettype wire

// ==== sarsr_consts.svh ====
// Purpose: shared constants of the serial readout link
// Assumes: 100 MHz system clock on both ends
// Notes:   counts in system clock cycles
`ifndef SARSR_CONSTS_SVH
`define SARSR_CONSTS_SVH
`define SARSR_RES_BITS     12
`define SARSR_CODE_MAX     12'hFFF
`define SARSR_CODE_MIN     12'h000
`define SARSR_FULL_SCALE   4096
`define SARSR_CLK_MHZ      100
`define SARSR_HOLD_US      1200
`define SARSR_HOLD_CYC     (`SARSR_HOLD_US * `SARSR_CLK_MHZ)
`define SARSR_SCLK_HALF    8'h08
`define SARSR_NUM_CLKS     5'h10
`endif

// ==== sarsr_device.sv ====
// Purpose: converter end, bit sequencer of a 12 bit readout
// Assumes: link pins asynchronous to i_clk, sampled twice
// Notes:
// Notes on behaviour
// - Host toggles select after power-up low
// - Acquire on first rising clock after select
// - Second falling edge ends sample, null low
// - Next twelve falling edges send MSB first
// - Output changes only on falling edges
// - Then LSB first starting at bit one
// - Afterwards zeros forever while selected
// - High impedance for first two clocks
// - One result bit per clock after sample
// - Host finishes twelve bits within 1.2 ms
// - Irregular clock tolerated
// - Host idles clock either level, samples rising
// - Byte host sends sixteen clocks, realigns
// - Code is 4096 times input over reference
// - Select high ends conversion, standby
// - Code saturates at 000h and FFFh
`default_nettype none
`include "sarsr_consts.svh"
module sarsr_device (
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  sarsr_if.device        link,
  input  wire logic [15:0] i_vin_mv,
  input  wire logic [15:0] i_vref_mv,
  output logic           o_busy,
  output logic [11:0]    o_code
);
  import sarsr_pkg::*;

  // ****************************************
  // Code from the analog values
  // ****************************************
  // Ideal transfer with clamp; analog modelled as millivolts
  function automatic logic [11:0] sarsr_convert(input logic [15:0] vin, input logic [15:0] vref);
    logic [27:0] num;
    logic [27:0] q;
    num = {12'h000, vin} << 12;
    q   = (vref == 16'h0000) ? 28'h0000FFF : num / {12'h000, vref};
    if (q > 28'h0000FFF) begin
      return `SARSR_CODE_MAX;
    end
    return q[11:0];
  endfunction : sarsr_convert

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] cs_sync_q, cs_sync_d;
  logic [1:0] ck_sync_q, ck_sync_d;
  logic       ck_last_q, ck_last_d;
  always_comb begin
    cs_sync_d = {cs_sync_q[0], link.select_shutdown_n};
    ck_sync_d = {ck_sync_q[0], link.sclk};
    ck_last_d = ck_sync_q[1];
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_sync_q <= 2'b00; // Reset as selected: only a real high on the pin arms
      ck_sync_q <= 2'b00;
      ck_last_q <= 1'b0;
    end else begin
      cs_sync_q <= cs_sync_d;
      ck_sync_q <= ck_sync_d;
      ck_last_q <= ck_last_d;
    end
  end
  logic cs_n;
  logic ck_rise;
  logic ck_fall;
  assign cs_n    = cs_sync_q[1];
  assign ck_rise = ck_sync_q[1] & ~ck_last_q;
  assign ck_fall = ~ck_sync_q[1] & ck_last_q;

  // ****************************************
  // Bit sequencer
  // ****************************************
  sarsr_phase_t phase_q, phase_d;
  logic [3:0]   idx_q, idx_d;
  logic [1:0]   falls_q, falls_d;
  logic         armed_q, armed_d;   // Select seen high since reset
  logic         sampled_q, sampled_d;
  logic [11:0]  code_q, code_d;
  logic         dout_q, dout_d;
  logic         oe_q, oe_d;
  // Edges are only acted on in the same cycle they are found, so a ragged clock is fine
  always_comb begin
    phase_d   = phase_q;
    idx_d     = idx_q;
    falls_d   = falls_q;
    armed_d   = armed_q;
    sampled_d = sampled_q;
    code_d    = code_q;
    dout_d    = dout_q;
    oe_d      = oe_q;
    if (cs_n) begin
      armed_d   = 1'b1;
      phase_d   = SARSR_IDLE;
      idx_d     = 4'h0;
      falls_d   = 2'b00;
      sampled_d = 1'b0;
      oe_d      = 1'b0;
      dout_d    = 1'b0;
    end else if (armed_q) begin
      unique case (phase_q)
        SARSR_IDLE: begin
          if (ck_rise) begin
            phase_d = SARSR_SAMPLE;
          end
        end
        SARSR_SAMPLE: begin
          if (ck_rise & ~sampled_q) begin
            code_d    = sarsr_convert(i_vin_mv, i_vref_mv); // Hold cap charged by now
            sampled_d = 1'b1;
          end
          if (ck_fall) begin
            falls_d = falls_q + 2'b01;
            if (falls_q == 2'b01) begin
              oe_d    = 1'b1;
              dout_d  = 1'b0;
              phase_d = SARSR_MSB;
              idx_d   = 4'hB;
            end
          end
        end
        SARSR_MSB: begin
          if (ck_fall) begin
            dout_d = code_q[idx_q];
            if (idx_q == 4'h0) begin
              phase_d = SARSR_LSB;
              idx_d   = 4'h1;
            end else begin
              idx_d = idx_q - 4'h1;
            end
          end
        end
        SARSR_LSB: begin
          if (ck_fall) begin
            dout_d = code_q[idx_q];
            if (idx_q == 4'hB) begin
              phase_d = SARSR_ZERO;
            end else begin
              idx_d = idx_q + 4'h1;
            end
          end
        end
        SARSR_ZERO: begin
          if (ck_fall) begin
            dout_d = 1'b0;
          end
        end
        default: phase_d = SARSR_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_q   <= SARSR_IDLE;
      idx_q     <= 4'h0;
      falls_q   <= 2'b00;
      armed_q   <= 1'b0;
      sampled_q <= 1'b0;
      code_q    <= `SARSR_CODE_MIN;
      dout_q    <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      idx_q     <= idx_d;
      falls_q   <= falls_d;
      armed_q   <= armed_d;
      sampled_q <= sampled_d;
      code_q    <= code_d;
      dout_q    <= dout_d;
      oe_q      <= oe_d;
    end
  end

  // Pin and user outputs
  assign link.miso_o  = dout_q;
  assign link.miso_oe = oe_q;
  assign o_busy       = (phase_q != SARSR_IDLE);
  assign o_code       = code_q;
endmodule : sarsr_device
`default_nettype wire

// ==== sarsr_host.sv ====
// Purpose: host end, issues sixteen clocks and reassembles the code
// Assumes: mode 0,0 by default, mode 1,1 via i_cpol
// Notes:   clock derived from i_clk by a divider
`default_nettype none
`include "sarsr_consts.svh"
module sarsr_host #(
  parameter logic [7:0] HALF_CYC = `SARSR_SCLK_HALF
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  sarsr_if.host            link,
  input  wire logic        i_start,
  input  wire logic        i_cpol,
  output logic             o_ready,
  output logic             o_valid,
  output logic [11:0]      o_code
);
  import sarsr_pkg::*;

  // ****************************************
  // Data pin synchroniser
  // ****************************************
  logic [1:0] di_sync_q, di_sync_d;
  always_comb di_sync_d = {di_sync_q[0], link.miso_o & link.miso_oe};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      di_sync_q <= 2'b00;
    end else begin
      di_sync_q <= di_sync_d;
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  sarsr_hstate_t st_q, st_d;
  logic [7:0]    div_q, div_d;
  logic [4:0]    nclk_q, nclk_d;
  logic          ph_q, ph_d;     // 0 first half (low when i_cpol is 0, high when 1), 1 second half
  logic [15:0]   sh_q, sh_d;
  logic          cs_q, cs_d;
  logic          valid_q, valid_d;
  logic [11:0]   code_q, code_d;
  logic [7:0]    lo_b, hi_b;
  // Sample as the low half ends, just before the rise; a half period covers the sync delay
  always_comb begin
    st_d = st_q; div_d = div_q; nclk_d = nclk_q; ph_d = ph_q;
    sh_d = sh_q; cs_d = cs_q; valid_d = 1'b0; code_d = code_q;
    lo_b = 8'h00;
    hi_b = 8'h00;
    unique case (st_q)
      SARSR_H_IDLE: begin
        if (i_start) begin
          st_d = SARSR_H_RUN; cs_d = 1'b0; div_d = HALF_CYC; nclk_d = 5'h00; ph_d = 1'b0;
        end
      end
      SARSR_H_RUN: begin
        if (div_q != 8'h00) begin
          div_d = div_q - 8'h01;
        end else begin
          div_d = HALF_CYC;
          ph_d  = ~ph_q;
          if (ph_q == i_cpol) begin
            sh_d = {sh_q[14:0], di_sync_q[1]};
          end
          if (ph_q) begin
            nclk_d = nclk_q + 5'h01;
            if (nclk_q == `SARSR_NUM_CLKS - 5'h01) begin
              st_d = SARSR_H_GAP; cs_d = 1'b1;
              hi_b = sh_d[15:8];
              lo_b = sh_d[7:0];
              lo_b = {hi_b[0], lo_b[7:1]};
              hi_b = {1'b0, hi_b[7:1]};
              code_d  = {hi_b[3:0], lo_b};
              valid_d = 1'b1;
            end
          end
        end
      end
      SARSR_H_GAP: begin
        if (div_q != 8'h00) begin
          div_d = div_q - 8'h01;
        end else begin
          st_d = SARSR_H_IDLE;
        end
      end
      default: st_d = SARSR_H_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= SARSR_H_IDLE; div_q <= 8'h00; nclk_q <= 5'h00; ph_q <= 1'b0;
      sh_q <= 16'h0000; cs_q <= 1'b1; valid_q <= 1'b0; code_q <= 12'h000;
    end else begin
      st_q <= st_d; div_q <= div_d; nclk_q <= nclk_d; ph_q <= ph_d;
      sh_q <= sh_d; cs_q <= cs_d; valid_q <= valid_d; code_q <= code_d;
    end
  end

  // Select high at reset gives the device its wake toggle
  assign link.select_shutdown_n = cs_q;
  assign link.sclk = ((st_q == SARSR_H_RUN) & ph_q) ^ i_cpol;
  assign o_ready = (st_q == SARSR_H_IDLE);
  assign o_valid = valid_q;
  assign o_code  = code_q;
endmodule : sarsr_host
`default_nettype wire

// ==== sarsr_if.sv ====
// Purpose: three wire link between host and converter
// Assumes: host masks the data line with its enable, no tristate net
// Notes:   data line is two signals
`default_nettype none
interface sarsr_if;
  logic select_shutdown_n;
  logic sclk;
  logic miso_o;
  logic miso_oe;
  modport device (input select_shutdown_n, input sclk, output miso_o, output miso_oe);
  modport host   (output select_shutdown_n, output sclk, input miso_o, input miso_oe);
endinterface : sarsr_if
`default_nettype wire

// ==== sarsr_pkg.sv ====
// Purpose: types of the serial readout link
// Assumes: nothing
// Notes:   device bit phases
`default_nettype none
package sarsr_pkg;
  typedef enum logic [2:0] {
    SARSR_IDLE   = 3'b000,
    SARSR_SAMPLE = 3'b001,
    SARSR_MSB    = 3'b011,
    SARSR_LSB    = 3'b010,
    SARSR_ZERO   = 3'b110
  } sarsr_phase_t;
  typedef enum logic [1:0] {
    SARSR_H_IDLE = 2'b00,
    SARSR_H_RUN  = 2'b01,
    SARSR_H_GAP  = 2'b11
  } sarsr_hstate_t;
endpackage : sarsr_pkg
`default_nettype wire
